// ### verilog/cgo_defs.svh
// Register map, field positions, reset values and codes of the channel gain, offset and filter block
`ifndef CGO_DEFS_SVH
`define CGO_DEFS_SVH

// Register indices as printed; the byte address is four times the index
`define CGO_IDX_GAIN_OFS     8'h37
`define CGO_IDX_OFS_COPY     8'h38
`define CGO_IDX_PAT_HPF      8'h39
`define CGO_ADDR_GAIN_OFS    {2'b00, `CGO_IDX_GAIN_OFS, 2'b00}
`define CGO_ADDR_OFS_COPY    {2'b00, `CGO_IDX_OFS_COPY, 2'b00}
`define CGO_ADDR_PAT_HPF     {2'b00, `CGO_IDX_PAT_HPF, 2'b00}
// Global enables and a sample counter, placed after the printed map
`define CGO_ADDR_GLOBAL_CTRL 12'h100
`define CGO_ADDR_STATUS      12'h104

// Reset value shared by every register
`define CGO_RST_REG          16'h0000

// Gain and offset register fields
`define CGO_GAIN_MSB         15
`define CGO_GAIN_LSB         11
`define CGO_OFS_MSB          9
`define CGO_OFS_LSB          0

// Pattern and filter register fields
`define CGO_PRBS_MSB         15
`define CGO_PRBS_LSB         12
`define CGO_CODE13_MSB       11
`define CGO_CODE13_LSB       9
`define CGO_CODE14_MSB       8
`define CGO_CODE14_LSB       6
`define CGO_CORNER_MSB       4
`define CGO_CORNER_LSB       1
`define CGO_HPF_EN_BIT       0

// Global control register fields
`define CGO_GAIN_EN_BIT      0
`define CGO_OFS_EN_BIT       1
`define CGO_IND_PAT_BIT      2
`define CGO_HPF_GRP3_BIT     3

// Fixed-point scaling: unity gain in Q12, filter state fraction bits
`define CGO_GAIN_UNITY       16'h1000
`define CGO_GAIN_FRAC        12
`define CGO_HPF_FRAC         8
`define CGO_SMP_MAX          14'h1FFF
`define CGO_SMP_MIN          14'h2000
`define CGO_PRBS_SEED        15'h7FFF
`define CGO_ALT_A            14'h2AAA
`define CGO_ALT_B            14'h1555
`define CGO_ALL_ONES         14'h3FFF

// AXI response codes
`define CGO_RESP_OKAY        2'b00
`define CGO_RESP_SLVERR      2'b10

`endif

// ### verilog/cgo_pkg.sv
// Types and the gain lookup table of the channel gain, offset and filter block
package cgo_pkg;

   // Signed 14-bit sample
   typedef logic signed [13:0] cgo_smp_t;

   // Fixed test pattern codes for outputs 13 and 14
   typedef enum logic [2:0] {
      CGO_PAT_NONE   = 3'h0,
      CGO_PAT_ZEROS  = 3'h1,
      CGO_PAT_ONES   = 3'h2,
      CGO_PAT_TOGGLE = 3'h3,
      CGO_PAT_RAMP   = 3'h4
   } cgo_pat_e;

   // Gain of N x 0.2 dB in Q12, N = 0 to 31
   localparam logic [15:0] CGO_GAIN_LUT [32] = '{
      16'h1000, 16'h105F, 16'h10C1, 16'h1125, 16'h118B, 16'h11F4, 16'h125F, 16'h12CC,
      16'h133C, 16'h13AF, 16'h1425, 16'h149D, 16'h1518, 16'h1595, 16'h1616, 16'h169A,
      16'h1720, 16'h17AA, 16'h1837, 16'h18C8, 16'h195C, 16'h19F3, 16'h1A8E, 16'h1B2C,
      16'h1BCE, 16'h1C74, 16'h1D1E, 16'h1DCB, 16'h1E7D, 16'h1F33, 16'h1FED, 16'h20AB};

endpackage

// ### verilog/cgo_buf2.sv
// Small FIFO between the sample datapath and the output stream
`timescale 1ns/1ns
`default_nettype none
module cgo_buf2 #(
   parameter int WIDTH = 56,
   parameter int DEPTH = 2
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Full and empty come straight from the fill count
   assign in_ready  = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage is not reset; nothing reads it while empty
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // cgo_buf2
`default_nettype wire

// ### verilog/cgo_top.sv
// Gain, offset, high-pass filter and test pattern stage for channels 13 to 16
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cgo_defs.svh"

// What this block does
// - Channel 16 gain field N scales that channel by N times 0.2 dB.
// - Gain applies only while the global gain enable is 1.
// - Channel 16 offset is 10-bit two's complement in 14-bit LSBs, added.
// - Offset applies only while the global offset enable is 1.
// - With independent select, per-output bits enable PRBS on outputs 13 to 16.
// - With independent select, 3-bit codes pick patterns for outputs 13 and 14.
// - Filter output is 2^k/(2^k+1) times (x(n) - x(n-1) + y(n-1)).
// - The corner field acts only while the group filter enable is 1.
// - Filter enable bit 0 resets to 0 (bypass); 1 filters all four channels.
// - All fields but the status sample count are read/write; all reset to zero.
module cgo_top
   import cgo_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        smp_valid,
   output logic             smp_ready,
   input  wire logic [13:0] smp_ch13,
   input  wire logic [13:0] smp_ch14,
   input  wire logic [13:0] smp_ch15,
   input  wire logic [13:0] smp_ch16,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [13:0]      out_ch13,
   output logic [13:0]      out_ch14,
   output logic [13:0]      out_ch15,
   output logic [13:0]      out_ch16
);
   logic        rst_meta_q;
   logic        rst_sync_b;
   logic [15:0] gain_ofs_q;
   logic [15:0] ofs_copy_q;
   logic [15:0] pat_hpf_q;
   logic [3:0]  global_ctrl_q;
   logic [15:0] smp_count_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_fire;
   logic        w_fire;
   logic        do_write;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        accept;
   logic        buf_in_ready;
   logic [55:0] buf_in_data;
   logic [55:0] buf_out_data;
   logic [14:0] prbs_q;
   logic        alt_q;
   logic [13:0] ramp_q;
   cgo_smp_t    smp_in [4];
   cgo_smp_t    filt [4];
   cgo_smp_t    proc [4];
   cgo_smp_t    final_smp [4];

   // Named register fields
   logic [4:0]  ch16_digital_gain;
   logic [9:0]  ch16_digital_offset;
   logic        global_gain_enable;
   logic        global_offset_enable;
   logic        independent_pattern_select;
   logic [3:0]  prbs_enable;
   logic [2:0]  pattern_code_out13;
   logic [2:0]  pattern_code_out14;
   logic [3:0]  filter_corner_k_group4;
   logic        filter_enable_group4;

   assign ch16_digital_gain          = gain_ofs_q[`CGO_GAIN_MSB:`CGO_GAIN_LSB];
   assign ch16_digital_offset        = gain_ofs_q[`CGO_OFS_MSB:`CGO_OFS_LSB];
   assign global_gain_enable         = global_ctrl_q[`CGO_GAIN_EN_BIT];
   assign global_offset_enable       = global_ctrl_q[`CGO_OFS_EN_BIT];
   assign independent_pattern_select = global_ctrl_q[`CGO_IND_PAT_BIT];
   assign prbs_enable                = pat_hpf_q[`CGO_PRBS_MSB:`CGO_PRBS_LSB];
   assign pattern_code_out13         = pat_hpf_q[`CGO_CODE13_MSB:`CGO_CODE13_LSB];
   assign pattern_code_out14         = pat_hpf_q[`CGO_CODE14_MSB:`CGO_CODE14_LSB];
   assign filter_corner_k_group4     = pat_hpf_q[`CGO_CORNER_MSB:`CGO_CORNER_LSB];
   assign filter_enable_group4       = pat_hpf_q[`CGO_HPF_EN_BIT];

   // Clamp a wide signed value into the 14-bit sample range
   function automatic cgo_smp_t sat14(input logic signed [31:0] v);
      if (v > 32'sd8191) begin
         sat14 = `CGO_SMP_MAX;
      end else if (v < -32'sd8192) begin
         sat14 = `CGO_SMP_MIN;
      end else begin
         sat14 = v[13:0];
      end
   endfunction

   // Reset release through two flops so every flop leaves reset on one edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // Write channel: address and data are taken in any order, answered once both are in
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign aw_fire       = s_axi_awvalid && s_axi_awready;
   assign w_fire        = s_axi_wvalid && s_axi_wready;
   assign do_write      = (aw_have_q || aw_fire) && (w_have_q || w_fire);
   assign wr_addr       = aw_have_q ? awaddr_q : s_axi_awaddr;
   assign wr_data       = w_have_q ? wdata_q : s_axi_wdata;
   assign wr_strb       = w_have_q ? wstrb_q : s_axi_wstrb;

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         awaddr_q     <= 12'h000;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CGO_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_addr == `CGO_ADDR_GAIN_OFS || wr_addr == `CGO_ADDR_OFS_COPY ||
                wr_addr == `CGO_ADDR_PAT_HPF || wr_addr == `CGO_ADDR_GLOBAL_CTRL ||
                wr_addr == `CGO_ADDR_STATUS) begin
               s_axi_bresp <= `CGO_RESP_OKAY;
            end else begin
               s_axi_bresp <= `CGO_RESP_SLVERR;
            end
         end else begin
            if (aw_fire) begin
               aw_have_q <= 1'b1;
               awaddr_q  <= s_axi_awaddr;
            end
            if (w_fire) begin
               w_have_q <= 1'b1;
               wdata_q  <= s_axi_wdata;
               wstrb_q  <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // Register storage; reserved bits are kept as written, all reset to zero
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         gain_ofs_q    <= `CGO_RST_REG;
         ofs_copy_q    <= `CGO_RST_REG;
         pat_hpf_q     <= `CGO_RST_REG;
         global_ctrl_q <= 4'h0;
      end else if (do_write) begin
         if (wr_addr == `CGO_ADDR_GAIN_OFS) begin
            if (wr_strb[0]) gain_ofs_q[7:0] <= wr_data[7:0];
            if (wr_strb[1]) gain_ofs_q[15:8] <= wr_data[15:8];
         end else if (wr_addr == `CGO_ADDR_OFS_COPY) begin
            if (wr_strb[0]) ofs_copy_q[7:0] <= wr_data[7:0];
            if (wr_strb[1]) ofs_copy_q[15:8] <= wr_data[15:8];
         end else if (wr_addr == `CGO_ADDR_PAT_HPF) begin
            if (wr_strb[0]) pat_hpf_q[7:0] <= wr_data[7:0];
            if (wr_strb[1]) pat_hpf_q[15:8] <= wr_data[15:8];
         end else if (wr_addr == `CGO_ADDR_GLOBAL_CTRL) begin
            if (wr_strb[0]) global_ctrl_q <= wr_data[3:0];
         end
      end
   end

   // Read channel: one read at a time, data one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `CGO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CGO_RESP_OKAY;
         if (s_axi_araddr == `CGO_ADDR_GAIN_OFS) begin
            s_axi_rdata <= {16'h0000, gain_ofs_q};
         end else if (s_axi_araddr == `CGO_ADDR_OFS_COPY) begin
            s_axi_rdata <= {16'h0000, ofs_copy_q};
         end else if (s_axi_araddr == `CGO_ADDR_PAT_HPF) begin
            s_axi_rdata <= {16'h0000, pat_hpf_q};
         end else if (s_axi_araddr == `CGO_ADDR_GLOBAL_CTRL) begin
            s_axi_rdata <= {28'h000_0000, global_ctrl_q};
         end else if (s_axi_araddr == `CGO_ADDR_STATUS) begin
            s_axi_rdata <= {16'h0000, smp_count_q};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CGO_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // A sample set is taken only when the output buffer has room, so stalls reach the source
   assign smp_ready = buf_in_ready;
   assign accept    = smp_valid && buf_in_ready;
   assign smp_in[0] = smp_ch13;
   assign smp_in[1] = smp_ch14;
   assign smp_in[2] = smp_ch15;
   assign smp_in[3] = smp_ch16;

   // First-order high-pass per channel; 1/(2^k+1) is a three-term series, error below 2^-3k
   for (genvar i = 0; i < 4; i++) begin : g_hpf
      logic signed [31:0] xs;
      logic signed [31:0] xps;
      logic signed [31:0] sum;
      logic signed [31:0] cut;
      logic signed [31:0] y;
      logic signed [31:0] yp_q;
      cgo_smp_t           xp_q;
      logic [5:0]         k1;

      always_comb begin
         k1  = {2'b00, filter_corner_k_group4};
         xs  = {{10{smp_in[i][13]}}, smp_in[i], 8'h00};
         xps = {{10{xp_q[13]}}, xp_q, 8'h00};
         sum = xs - xps + yp_q;
         cut = (sum >>> k1) - (sum >>> (k1 << 1)) + (sum >>> (k1 + (k1 << 1)));
         y   = sum - cut;
      end

      // Input history is kept while bypassed and output history held at zero, so enabling does not start from a stale sample
      always_ff @(posedge sys_clk or negedge rst_sync_b) begin
         if (!rst_sync_b) begin
            xp_q <= 14'h0000;
            yp_q <= 32'h0000_0000;
         end else if (accept) begin
            xp_q <= smp_in[i];
            yp_q <= filter_enable_group4 ? y : 32'h0000_0000;
         end
      end

      assign filt[i] = filter_enable_group4 ? sat14(y >>> `CGO_HPF_FRAC) : smp_in[i];
   end

   // Channel 16 gain and offset; channels 13 to 15 pass through here
   logic [15:0]        gain_q12;
   logic signed [31:0] prod;
   logic signed [31:0] ofs_ext;

   always_comb begin
      gain_q12 = global_gain_enable ? CGO_GAIN_LUT[ch16_digital_gain] : `CGO_GAIN_UNITY;
      prod     = 32'(filt[3]) * $signed({16'h0000, gain_q12});
      ofs_ext  = global_offset_enable ? 32'($signed(ch16_digital_offset)) : 32'h0000_0000;
   end

   assign proc[0] = filt[0];
   assign proc[1] = filt[1];
   assign proc[2] = filt[2];
   assign proc[3] = sat14((prod >>> `CGO_GAIN_FRAC) + ofs_ext);

   // Pattern sources advance once per accepted sample set
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         prbs_q <= `CGO_PRBS_SEED;
         alt_q  <= 1'b0;
         ramp_q <= 14'h0000;
      end else if (accept) begin
         prbs_q <= {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
         alt_q  <= !alt_q;
         ramp_q <= ramp_q + 14'h0001;
      end
   end

   // Per-output pattern override; PRBS takes priority over a fixed code
   for (genvar i = 0; i < 4; i++) begin : g_pat
      logic [2:0] code;
      cgo_smp_t   fixed;

      always_comb begin
         code  = (i == 0) ? pattern_code_out13 : (i == 1) ? pattern_code_out14 : 3'h0;
         fixed = proc[i];
         if (independent_pattern_select) begin
            case (code)
               CGO_PAT_ZEROS:  fixed = 14'h0000;
               CGO_PAT_ONES:   fixed = `CGO_ALL_ONES;
               CGO_PAT_TOGGLE: fixed = alt_q ? `CGO_ALT_B : `CGO_ALT_A;
               CGO_PAT_RAMP:   fixed = ramp_q;
               default:        fixed = proc[i];
            endcase
         end
      end

      // A pattern bypasses filter, gain and offset entirely
      assign final_smp[i] = (independent_pattern_select && prbs_enable[3-i]) ? prbs_q[13:0] : fixed;
   end

   // Count of sample sets accepted, visible in the status register
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         smp_count_q <= 16'h0000;
      end else if (accept) begin
         smp_count_q <= smp_count_q + 16'h0001;
      end
   end

   assign buf_in_data = {final_smp[3], final_smp[2], final_smp[1], final_smp[0]};

   // Two-entry buffer so a stall by the receiver loses no sample set
   cgo_buf2 #(
      .WIDTH (56),
      .DEPTH (2)
   ) u_buf (
      .sys_clk   (sys_clk),
      .rst_b     (rst_sync_b),
      .in_valid  (smp_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (buf_out_data)
   );

   assign out_ch13 = buf_out_data[13:0];
   assign out_ch14 = buf_out_data[27:14];
   assign out_ch15 = buf_out_data[41:28];
   assign out_ch16 = buf_out_data[55:42];
endmodule // cgo_top
`default_nettype wire

// ### bench/cgo_sink.sv
// Receiver model that captures the processed sample words
`timescale 1ns/1ns
`default_nettype none
module cgo_sink (
   input  wire logic        sys_clk,
   input  wire logic        slow,
   input  wire logic        out_valid,
   output logic             out_ready,
   input  wire logic [13:0] out_ch13,
   input  wire logic [13:0] out_ch14,
   input  wire logic [13:0] out_ch15,
   input  wire logic [13:0] out_ch16
);
   logic [1:0]  ph_q = 2'h0;
   logic [55:0] got_q [$];
   // When slow, accept only one cycle in four so the buffer fills up
   assign out_ready = !slow || (ph_q == 2'h3);
   // Capture every word taken; the bench pops them in order
   always @(posedge sys_clk) begin
      ph_q <= ph_q + 2'h1;
      if (out_valid && out_ready) got_q.push_back({out_ch13, out_ch14, out_ch15, out_ch16});
   end
endmodule // cgo_sink
`default_nettype wire

// ### bench/cgo_top_sva.sv
// Handshake and latency checks at the ports of the gain, offset and filter stage
`timescale 1ns/1ns
`default_nettype none
module cgo_top_sva (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        smp_valid,
   input wire logic        smp_ready,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [13:0] out_ch16
);
   // One clock domain, so clock and reset are named once
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_aw_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_ref: assert property (p_aw_ref) else $error("write taken while answering");
   property p_ar_ref; s_axi_arready == !s_axi_rvalid; endproperty
   a_ar_ref: assert property (p_ar_ref) else $error("read ready wrong");
   property p_lat; smp_valid && smp_ready |=> out_valid; endproperty
   a_lat: assert property (p_lat) else $error("sample not presented next cycle");
   property p_o_hold; out_valid && !out_ready |=> out_valid && $stable(out_ch16); endproperty
   a_o_hold: assert property (p_o_hold) else $error("stalled word lost");
   // Main scenarios reached
   c_full: cover property (!smp_ready);
   c_stall: cover property (out_valid && !out_ready);
   c_bwait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // cgo_top_sva
bind cgo_top cgo_top_sva chk_u (.*);
`default_nettype wire

// ### bench/cgo_top_tb.sv
// Self-checking bench of the gain, offset, filter and pattern stage
`timescale 1ns/1ns
`default_nettype none
`include "cgo_defs.svh"
module cgo_top_tb
   import cgo_pkg::*;
   ;
   localparam logic [11:0] AG = `CGO_ADDR_GAIN_OFS, AC = `CGO_ADDR_OFS_COPY;
   localparam logic [11:0] AP = `CGO_ADDR_PAT_HPF, AX = `CGO_ADDR_GLOBAL_CTRL;
   localparam logic [1:0]  OK = `CGO_RESP_OKAY, ER = `CGO_RESP_SLVERR;
   logic        sys_clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h3;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_bvalid;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, smp_valid = 1'b0, s_axi_rvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_arready, smp_ready, out_valid, out_ready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [13:0] smp_ch13 = 14'h0000, smp_ch14 = 14'h0000, smp_ch15 = 14'h0000, smp_ch16 = 14'h0000;
   logic [13:0] out_ch13, out_ch14, out_ch15, out_ch16;
   logic [11:0] ra [3] = '{AG, AC, AP};
   logic [15:0] rv [3] = '{16'hFBFF, 16'h03FF, 16'hFFD4};
   int          n_errors = 0, comparisons = 0;
   // Block under test and its receiver
   cgo_top dut_u (.*);
   cgo_sink sink_u (.*);
   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycles: response ready goes up with the request and stays until the answer is seen
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
      int i;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (i == 40) tmo();
      s_axi_bready <= 1'b0;
      chk(56'(s_axi_bresp), 56'(e));
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
      int i;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (i == 40) tmo();
      s_axi_rready <= 1'b0;
      chk(56'({s_axi_rresp, s_axi_rdata}), 56'({e, 16'h0000, d}));
   endtask
   task automatic snd(input logic [55:0] w);
      int i;
      @(posedge sys_clk);
      {smp_ch13, smp_ch14, smp_ch15, smp_ch16} <= w;
      smp_valid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (smp_ready) break;
      end
      if (i == 40) tmo();
      smp_valid <= 1'b0;
   endtask
   task automatic get(output logic [55:0] w);
      int i;
      for (i = 0; i < 200 && sink_u.got_q.size() == 0; i++) @(posedge sys_clk);
      if (i == 200) tmo();
      w = sink_u.got_q.pop_front();
   endtask
   // Reference models: gain then offset with saturation, filter with 8 fraction bits
   function automatic logic [13:0] gofs(int x, int n, int o);
      int v;
      v = ((x * int'(CGO_GAIN_LUT[n])) >>> 12) + o;
      if (v > 8191) v = 8191;
      if (v < -8192) v = -8192;
      return v[13:0];
   endfunction
   function automatic int hpf(int x, int xp, int k, inout int y);
      int s;
      s = ((x - xp) <<< 8) + y;
      y = s - (s >>> k) + (s >>> (2 * k)) - (s >>> (3 * k));
      return y >>> 8;
   endfunction
   function automatic logic [13:0] pexp(int c, logic [13:0] p);
      case (c)
         1: return 14'h0000;
         2: return 14'h3FFF;
         3: return ~p;
         4: return p + 14'h0001;
         default: return 14'h0055;
      endcase
   endfunction
   task automatic t_regs();
      for (int i = 0; i < 3; i++) rd(ra[i], 16'h0000, OK);
      for (int i = 0; i < 3; i++) wr(ra[i], rv[i], OK);
      for (int i = 0; i < 3; i++) rd(ra[i], rv[i], OK);
      wr(12'h0F0, 16'h1234, ER);
      rd(12'h0F0, 16'h0000, ER);
      $display("test registers done");
   endtask
   // Everything programmed but global and filter enables off: data passes through a stalled sink
   task automatic t_bypass();
      logic [55:0] w;
      wr(AX, 16'h0000, OK);
      wr(AG, 16'hF805, OK);
      wr(AC, 16'h0005, OK);
      wr(AP, 16'hF284, OK);
      slow <= 1'b1;
      for (int i = 0; i < 6; i++) snd({14'(i * 100), 14'h1FFF, 14'h2000, 14'h3FF9});
      for (int i = 0; i < 6; i++) begin
         get(w);
         chk(w, {14'(i * 100), 14'h1FFF, 14'h2000, 14'h3FF9});
      end
      slow <= 1'b0;
      $display("test bypass done");
   endtask
   task automatic t_gain();
      logic [55:0] w;
      int c, i;
      int xs [3] = '{1000, -1000, 8191};
      wr(AG, 16'hA3F8, OK);
      wr(AC, 16'h03F8, OK);
      wr(AP, 16'h0004, OK);
      for (c = 1; c < 4; c++) begin
         wr(AX, 16'(c), OK);
         for (i = 0; i < 3; i++) begin
            snd({{3{14'h0123}}, 14'(xs[i])});
            get(w);
            chk(w, {{3{14'h0123}}, gofs(xs[i], c[0] ? 20 : 0, c[1] ? -8 : 0)});
         end
      end
      $display("test gain and offset done");
   endtask
   task automatic t_hpf();
      logic [55:0] w;
      int k, i, y;
      wr(AX, 16'h0008, OK);
      for (k = 2; k < 11; k += 8) begin
         wr(AP, 16'(k * 2), OK);
         snd({4{14'h0000}});
         get(w);
         chk(w, 56'h0);
         wr(AP, 16'(k * 2 + 1), OK);
         y = 0;
         for (i = 0; i < 4; i++) begin
            snd({4{14'h03E8}});
            get(w);
            chk(w, {4{14'(hpf(1000, i == 0 ? 0 : 1000, k, y))}});
         end
      end
      $display("test filter done");
   endtask
   task automatic t_pat();
      logic [55:0] w0, w1;
      int c;
      wr(AX, 16'h0004, OK);
      for (c = 0; c < 6; c++) begin
         wr(AP, {4'h0, c[2:0], c[2:0], 6'h04}, OK);
         snd({4{14'h0055}});
         snd({4{14'h0055}});
         get(w0);
         get(w1);
         chk(w1, {pexp(c, w0[55:42]), pexp(c, w0[41:28]), {2{14'h0055}}});
      end
      wr(AP, 16'hF204, OK);
      snd({4{14'h0055}});
      snd({4{14'h0055}});
      get(w0);
      get(w1);
      chk(56'({w1[55:43], w1[13:0]}), 56'({w0[54:42], w1[55:42]}));
      $display("test patterns done");
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_regs();
      t_bypass();
      t_gain();
      t_hpf();
      t_pat();
      close_out();
   end
endmodule // cgo_top_tb
`default_nettype wire
